// File: nirqh_pkg.sv
// Purpose: shared constants for the nested irq priority and halt block
// Assumes: clk is the cpu clock (oscillator / 2), one register per word
// Notes: byte address of a register is four times its index
package nirqh_pkg;
  // register indices
  localparam logic [7:0] IDX_PRIO0 = 8'h1C;
  localparam logic [7:0] IDX_PRIO1 = 8'h1D;
  localparam logic [7:0] IDX_PRIO2 = 8'h1E;
  localparam logic [7:0] IDX_PRIO3 = 8'h1F;
  localparam logic [7:0] IDX_CC = 8'h20;
  localparam logic [7:0] IDX_CTRL = 8'h21;
  localparam logic [7:0] IDX_STAT = 8'h22;
  // reset values and fixed bits
  localparam logic [7:0] CC_RESET = 8'hEA;
  localparam logic [7:0] PRIO_RESET = 8'hFF;
  localparam logic [7:0] PRIO3_RO = 8'hF0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int CC_BIT_HIGH = 5;
  localparam int CC_BIT_LOW = 3;
  localparam int CTRL_OIE_BIT = 1;
  // level codes
  localparam logic [1:0] LVL0 = 2'b10;
  localparam logic [1:0] LVL1 = 2'b01;
  localparam logic [1:0] LVL2 = 2'b00;
  localparam logic [1:0] LVL3 = 2'b11;
  // vectors
  localparam int NUM_VEC = 14;
  localparam logic [3:0] VEC_NMI = 4'h0;
  localparam logic [3:0] VEC_TRAP = 4'hE;
  localparam logic [3:0] VEC_RESET = 4'hF;
  localparam logic [13:0] EXT_MASK = 14'h003E;
  localparam logic [13:0] HALT_EXIT_MASK = 14'h007F;
  // timing: cycles of the cpu clock
  localparam int WAKE_CYCLES = 4096;
  // halt state machine
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_WAKE = 3'b100
  } nirqh_state_t;
  // ordinal of a level code: 10->0, 01->1, 00->2, 11->3
  function automatic logic [1:0] levelRank(input logic [1:0] code);
    levelRank = {~(code[1] ^ code[0]), code[0]};
  endfunction
  // keep a field when the level-0 pattern is written
  function automatic logic [7:0] prioMerge(input logic [7:0] old, input logic [7:0] wr);
    logic [7:0] res;
    res = wr;
    for (int f = 0; f < 4; f++) begin
      if (wr[2*f +: 2] == LVL0) begin
        res[2*f +: 2] = old[2*f +: 2];
      end
    end
    prioMerge = res;
  endfunction
endpackage

// File: nirqh_arb_if.sv
`timescale 1ns/1ps
// Purpose: carries arbitration inputs and the winner between top and arbiter
// Assumes: one clock, purely combinational traffic
// Notes: fields holds 2 bits per vector, vector x at [2x+1:2x]
interface nirqh_arb_if;
  logic [13:0] pending;
  logic [27:0] fields;
  logic [1:0] curLevel;
  logic exitOnly;
  logic winValid;
  logic [3:0] winIdx;
  modport arb (input pending, fields, curLevel, exitOnly, output winValid, winIdx);
  modport ctl (output pending, fields, curLevel, exitOnly, input winValid, winIdx);
endinterface

// File: nirqh_req_latch.sv
`timescale 1ns/1ps
// Purpose: one request latch, edge or level sensitive
// Assumes: req already gated by its peripheral enable
// Notes: a new edge in the clearing cycle keeps the latch set
module nirqh_req_latch (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // request side
  input wire logic req,
  input wire logic edgeMode,
  input wire logic clear,
  output logic pending
);
  logic reqDly_reg;
  logic pend_reg;
  logic rise;

  // rising edge of the request
  assign rise = req & ~reqDly_reg;
  assign pending = edgeMode ? pend_reg : req;

  // edge latch, set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      reqDly_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      reqDly_reg <= req;
      if (rise) begin
        pend_reg <= 1'b1;
      end else if (clear) begin
        pend_reg <= 1'b0;
      end
    end
  end
endmodule

// File: nirqh_arbiter.sv
`timescale 1ns/1ps
// Purpose: picks the maskable vector to service
// Assumes: pending already includes enables
// Notes: index 0 (pin nmi) is skipped here and handled by the top
module nirqh_arbiter (
  // arbitration traffic
  nirqh_arb_if.arb a
);
  import nirqh_pkg::*;
  logic [1:0] bestRank;
  logic found;
  logic [3:0] bestIdx;

  // scan low priority upward so the lower index wins ties
  always_comb begin
    logic [1:0] r;
    r = 2'b00;
    bestRank = 2'b00;
    found = 1'b0;
    bestIdx = 4'h0;
    for (int i = NUM_VEC - 1; i >= 1; i--) begin
      r = levelRank(a.fields[2*i +: 2]);
      if (a.pending[i] && (r > levelRank(a.curLevel))
          && (!a.exitOnly || HALT_EXIT_MASK[i])
          && (!found || r >= bestRank)) begin
        found = 1'b1;
        bestRank = r;
        bestIdx = 4'(i);
      end
    end
  end

  assign a.winValid = found;
  assign a.winIdx = bestIdx;
endmodule

// File: nirqh_ctrl.sv
`timescale 1ns/1ps
// Purpose: nested priority control, priority registers and halt sequencing
// Assumes: core pulses instruction strobes at instruction end; AHB-Lite slave
// Notes: no wait states; response always OKAY
module nirqh_ctrl #(
  parameter int WAKE_COUNT = nirqh_pkg::WAKE_CYCLES
) (
  // clock and reset
  clk,
  srst,
  // AHB-Lite slave
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hreadyout,
  hresp,
  hrdata,
  // request sources
  irqReq,
  extEdgeMode,
  watchdogEnable,
  // core sequencer
  instrDone,
  unmaskInstr,
  maskInstr,
  haltInstr,
  waitForIrqInstr,
  trapInstr,
  irqReturnInstr,
  popFlagsInstr,
  stackLevel,
  serviceStart,
  serviceVector,
  levelBitHigh,
  levelBitLow,
  jumpIfMasked,
  jumpIfUnmasked,
  cpuStall,
  // clocks and watchdog
  oscRunning,
  periphClockEnable,
  watchdogReset
);
  import nirqh_pkg::*;

  // clock and reset
  input wire logic clk;
  input wire logic srst;
  // AHB-Lite slave
  input wire logic hsel;
  input wire logic [31:0] haddr;
  input wire logic [1:0] htrans;
  input wire logic hwrite;
  input wire logic [2:0] hsize;
  input wire logic [31:0] hwdata;
  input wire logic hready;
  output logic hreadyout;
  output logic hresp;
  output logic [31:0] hrdata;
  // request sources
  input wire logic [13:0] irqReq;
  input wire logic [4:0] extEdgeMode;
  input wire logic watchdogEnable;
  // core sequencer
  input wire logic instrDone;
  input wire logic unmaskInstr;
  input wire logic maskInstr;
  input wire logic haltInstr;
  input wire logic waitForIrqInstr;
  input wire logic trapInstr;
  input wire logic irqReturnInstr;
  input wire logic popFlagsInstr;
  input wire logic [1:0] stackLevel;
  output logic serviceStart;
  output logic [3:0] serviceVector;
  output logic levelBitHigh;
  output logic levelBitLow;
  output logic jumpIfMasked;
  output logic jumpIfUnmasked;
  output logic cpuStall;
  // clocks and watchdog
  output logic oscRunning;
  output logic periphClockEnable;
  output logic watchdogReset;

  // ****************************************
  // state
  // ****************************************
  logic [7:0] prio_reg [4];
  logic [1:0] cc_reg;
  logic [1:0] cc_next;
  logic [7:0] ctrl_reg;
  nirqh_state_t state_reg;
  nirqh_state_t state_next;
  logic [12:0] wake_reg;
  logic fullHalt_reg;
  logic exitOnly_reg;
  logic resetPend_reg;
  logic svc_reg;
  logic [3:0] vec_reg;
  logic wdog_reg;
  logic wrPend_reg;
  logic [7:0] wrIdx_reg;
  logic [31:0] rdata_reg;

  // ****************************************
  // request latches and arbitration
  // ****************************************
  nirqh_arb_if arbBus ();
  logic [13:0] pending;
  logic [13:0] clearVec;
  logic [13:0] edgeSel;

  // nmi pin is edge, groups per their mode, peripherals level
  assign edgeSel = {8'h00, extEdgeMode, 1'b1};

  genvar gv;
  generate
    for (gv = 0; gv < NUM_VEC; gv++) begin : g_lat
      nirqh_req_latch u_lat (
        .clk(clk),
        .srst(srst),
        .req(irqReq[gv]),
        .edgeMode(edgeSel[gv]),
        .clear(clearVec[gv]),
        .pending(pending[gv])
      );
    end
  endgenerate

  // arbiter inputs
  assign arbBus.pending = pending;
  assign arbBus.fields = {prio_reg[3][3:0], prio_reg[2], prio_reg[1], prio_reg[0]};
  assign arbBus.curLevel = cc_reg;
  assign arbBus.exitOnly = exitOnly_reg;

  nirqh_arbiter u_arb (
    .a(arbBus)
  );

  // ****************************************
  // service decision
  // ****************************************
  logic inRun;
  logic canTake;
  logic takeReset;
  logic takeTrap;
  logic takeNmi;
  logic takeMask;
  logic svcGo;
  logic [3:0] svcVec;
  logic [1:0] winField;

  // fixed order: reset, trap, nmi pin, then maskable winner
  assign inRun = (state_reg == ST_RUN);
  assign canTake = inRun & instrDone & ~svc_reg;
  assign takeReset = inRun & resetPend_reg & ~svc_reg;
  assign takeTrap = canTake & ~takeReset & trapInstr;
  assign takeNmi = canTake & ~takeReset & ~trapInstr & pending[VEC_NMI];
  assign takeMask = canTake & ~takeReset & ~trapInstr & ~pending[VEC_NMI] & arbBus.winValid;
  assign svcGo = takeReset | takeTrap | takeNmi | takeMask;
  assign svcVec = takeReset ? VEC_RESET : takeTrap ? VEC_TRAP : takeNmi ? VEC_NMI : arbBus.winIdx;
  assign winField = arbBus.fields[{arbBus.winIdx, 1'b0} +: 2];

  // clear the serviced latch on entry
  assign clearVec = (takeNmi | takeMask) ? (14'h0001 << svcVec) : 14'h0000;

  // ****************************************
  // halt sequencing
  // ****************************************
  logic haltGo;
  logic wakeReq;
  logic wakeDone;

  assign haltGo = inRun & haltInstr & ~svcGo;
  assign wakeReq = |(pending & (HALT_EXIT_MASK | EXT_MASK));
  assign wakeDone = (wake_reg == 13'(WAKE_COUNT - 1));

  // run, halt, wake delay
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (haltGo) begin
          state_next = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wakeReq) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wakeDone) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  // core and clock controls
  assign cpuStall = ~inRun;
  assign oscRunning = ~((state_reg == ST_HALT) & fullHalt_reg);
  assign periphClockEnable = inRun;
  assign watchdogReset = wdog_reg;

  // ****************************************
  // current level
  // ****************************************
  logic busWrCc;
  logic [7:0] ccView;

  assign busWrCc = wrPend_reg & (wrIdx_reg == IDX_CC);

  // entry beats instructions, instructions beat bus writes
  always_comb begin
    cc_next = cc_reg;
    if (svcGo) begin
      if (takeMask) begin
        cc_next = winField;
      end else begin
        cc_next = LVL3;
      end
    end else if (irqReturnInstr | popFlagsInstr) begin
      cc_next = stackLevel;
    end else if (maskInstr) begin
      cc_next = LVL3;
    end else if (unmaskInstr | waitForIrqInstr | haltGo) begin
      cc_next = LVL0;
    end else if (busWrCc) begin
      cc_next = {hwdata[CC_BIT_HIGH], hwdata[CC_BIT_LOW]};
    end
  end

  // level bits and mask tests for the core
  assign levelBitHigh = cc_reg[1];
  assign levelBitLow = cc_reg[0];
  assign jumpIfMasked = (cc_reg == LVL3);
  assign jumpIfUnmasked = (cc_reg != LVL3);

  // condition-code view with the level bits in place
  always_comb begin
    ccView = CC_RESET;
    ccView[CC_BIT_HIGH] = cc_reg[1];
    ccView[CC_BIT_LOW] = cc_reg[0];
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic addrPhase;
  logic [7:0] rIdx;
  logic [7:0] rdMux;
  logic [7:0] statView;

  assign addrPhase = hsel & htrans[1] & hready;
  assign rIdx = haddr[9:2];
  assign statView = {3'b000, exitOnly_reg, fullHalt_reg, state_reg};

  // register read select
  assign rdMux = (haddr[31:10] != 22'h0) ? 8'h00 :
                 (rIdx == IDX_PRIO0) ? prio_reg[0] :
                 (rIdx == IDX_PRIO1) ? prio_reg[1] :
                 (rIdx == IDX_PRIO2) ? prio_reg[2] :
                 (rIdx == IDX_PRIO3) ? (prio_reg[3] | PRIO3_RO) :
                 (rIdx == IDX_CC) ? ccView :
                 (rIdx == IDX_CTRL) ? ctrl_reg :
                 (rIdx == IDX_STAT) ? statView :
                 8'h00;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;

  // address phase capture and read data
  always_ff @(posedge clk) begin
    if (srst) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wrPend_reg <= addrPhase & hwrite & (haddr[31:10] == 22'h0);
      wrIdx_reg <= rIdx;
      if (addrPhase & ~hwrite) begin
        rdata_reg <= {24'h000000, rdMux};
      end
    end
  end

  // priority and control register writes
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int r = 0; r < 4; r++) begin
        prio_reg[r] <= PRIO_RESET;
      end
      ctrl_reg <= CTRL_RESET;
    end else if (wrPend_reg) begin
      for (int r = 0; r < 4; r++) begin
        if (wrIdx_reg == IDX_PRIO0 + 8'(r)) begin
          prio_reg[r] <= prioMerge(prio_reg[r], hwdata[7:0]);
        end
      end
      if (wrIdx_reg == IDX_CTRL) begin
        ctrl_reg <= {6'h00, hwdata[CTRL_OIE_BIT], 1'b0};
      end
    end
  end

  // ****************************************
  // sequential core
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      cc_reg <= LVL3;
      state_reg <= ST_RUN;
      wake_reg <= 13'h0000;
      fullHalt_reg <= 1'b0;
      exitOnly_reg <= 1'b0;
      resetPend_reg <= 1'b1;
      svc_reg <= 1'b0;
      vec_reg <= 4'h0;
      wdog_reg <= 1'b0;
    end else begin
      cc_reg <= cc_next;
      state_reg <= state_next;
      svc_reg <= svcGo;
      wdog_reg <= 1'b0;
      if (svcGo) begin
        vec_reg <= svcVec;
        resetPend_reg <= 1'b0;
        exitOnly_reg <= 1'b0;
      end
      if (haltGo) begin
        fullHalt_reg <= ~ctrl_reg[CTRL_OIE_BIT];
        wdog_reg <= ~ctrl_reg[CTRL_OIE_BIT] & watchdogEnable;
      end
      if (state_reg == ST_WAKE) begin
        wake_reg <= wake_reg + 13'h0001;
        if (wakeDone) begin
          exitOnly_reg <= 1'b1;
        end
      end else begin
        wake_reg <= 13'h0000;
      end
    end
  end

  // entry strobe to the core, which stacks before loading the vector
  assign serviceStart = svc_reg;
  assign serviceVector = vec_reg;
endmodule

// File: nirqh_ctrl_assertions.sv
// Purpose: port-level checks for the nested priority and halt block
// Assumes: one clock, srst synchronous active high
// Notes: wake count handed on from the bound instance
`timescale 1ns/1ps
module nirqh_ctrl_assertions #(
  parameter int WAKE_COUNT = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // core side
  input wire logic instrDone,
  input wire logic unmaskInstr,
  input wire logic maskInstr,
  input wire logic haltInstr,
  input wire logic trapInstr,
  input wire logic irqReturnInstr,
  input wire logic popFlagsInstr,
  input wire logic [1:0] stackLevel,
  input wire logic watchdogEnable,
  // block outputs
  input wire logic serviceStart,
  input wire logic [3:0] serviceVector,
  input wire logic levelBitHigh,
  input wire logic levelBitLow,
  input wire logic jumpIfMasked,
  input wire logic jumpIfUnmasked,
  input wire logic cpuStall,
  input wire logic oscRunning,
  input wire logic periphClockEnable,
  input wire logic watchdogReset
);
  import nirqh_pkg::*;
  logic [1:0] lvl;
  logic [12:0] wakeCnt_reg;
  logic fullSeen_reg;
  // ****************
  // helper logic
  // ****************
  assign lvl = {levelBitHigh, levelBitLow};
  // stall cycles with the oscillator back, and whether a full halt came first
  always_ff @(posedge clk) begin
    wakeCnt_reg <= (srst || !cpuStall || !oscRunning) ? 13'h0000 : wakeCnt_reg + 13'h0001;
    fullSeen_reg <= !srst && cpuStall && (fullSeen_reg || !oscRunning);
  end
  // ****************
  // checks
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence resetVecS;
    serviceStart && serviceVector == VEC_RESET && !cpuStall;
  endsequence
  sequence topLevelS;
    lvl == LVL3;
  endsequence
  reset_entry_a: assert property ($fell(srst) |-> topLevelS ##1 (resetVecS and topLevelS))
    else $error("reset entry wrong");
  jump_decode_a: assert property (jumpIfMasked == (lvl == LVL3) && jumpIfUnmasked == (lvl != LVL3))
    else $error("jump decode wrong");
  unmask_level_a: assert property (unmaskInstr && !instrDone |=> lvl == LVL0)
    else $error("enable level wrong");
  mask_level_a: assert property (maskInstr && !instrDone |=> topLevelS)
    else $error("disable level wrong");
  restore_level_a: assert property ((irqReturnInstr || popFlagsInstr) && !instrDone |=> lvl == $past(stackLevel))
    else $error("restored level wrong");
  halt_entry_a: assert property (haltInstr && !instrDone && !cpuStall |=>
    cpuStall && lvl == LVL0 && watchdogReset == ($past(watchdogEnable) && !oscRunning)) else $error("halt entry wrong");
  trap_entry_a: assert property (trapInstr && instrDone && !serviceStart && !cpuStall |=>
    (serviceStart && serviceVector == VEC_TRAP) and topLevelS) else $error("trap entry wrong");
  start_pulse_a: assert property (serviceStart |-> !cpuStall ##1 !serviceStart)
    else $error("service pulse wrong");
  clock_gate_a: assert property (periphClockEnable == !cpuStall && (oscRunning || cpuStall))
    else $error("clock gating wrong");
  wake_delay_a: assert property ($fell(cpuStall) && fullSeen_reg |-> wakeCnt_reg == WAKE_COUNT)
    else $error("wake delay wrong");
endmodule
bind nirqh_ctrl nirqh_ctrl_assertions #(.WAKE_COUNT(WAKE_COUNT)) chk (.clk, .srst, .instrDone, .unmaskInstr,
  .maskInstr, .haltInstr, .trapInstr, .irqReturnInstr, .popFlagsInstr, .stackLevel, .watchdogEnable, .serviceStart,
  .serviceVector, .levelBitHigh, .levelBitLow, .jumpIfMasked, .jumpIfUnmasked, .cpuStall, .oscRunning,
  .periphClockEnable, .watchdogReset);

// File: nirqh_core_model.sv
// Purpose: core sequencer stand-in that ends instructions and issues traps
// Assumes: one instruction ends every second cycle while running
// Notes: the bench drives the level-changing instructions itself
`timescale 1ns/1ps
module nirqh_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bench control
  input wire logic run,
  input wire logic trapReq,
  // block side
  input wire logic cpuStall,
  output logic instrDone,
  output logic trapInstr
);
  logic phase_reg;
  // ****************
  // sequencer
  // ****************
  // instruction ends pause while the block stalls the core
  always_ff @(posedge clk) begin
    phase_reg <= !srst && run && !cpuStall && !phase_reg;
  end
  // only a trap leaves the core on its own, never a level change
  assign instrDone = phase_reg;
  assign trapInstr = phase_reg && trapReq;
endmodule

// File: nested_irq_priority_halt_test.sv
// Purpose: self-checking bench for the nested priority and halt block
// Assumes: 50 MHz clock, wake count shortened to 8
// Notes: core model supplies instruction ends and traps
`timescale 1ns/1ps
`define CHK(nm, got, exp) begin total_checks++; if ((got) !== (exp)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module nested_irq_priority_halt_test;
  import nirqh_pkg::*;
  localparam int WAKE = 8;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h00000000;
  logic [13:0] irqReq = 14'h0000;
  logic [4:0] extEdgeMode = 5'h00;
  logic watchdogEnable = 1'b0;
  logic [6:0] instr = 7'h00;
  logic [1:0] stackLevel = 2'h0;
  logic run = 1'b0;
  logic trapReq = 1'b0;
  logic hreadyout, hresp, serviceStart, levelBitHigh, levelBitLow, jumpIfMasked, jumpIfUnmasked;
  logic cpuStall, oscRunning, periphClockEnable, watchdogReset, instrDone, trapInstr;
  logic [31:0] hrdata;
  logic [3:0] serviceVector;
  logic [1:0] lvl;
  int err_total = 0;
  int total_checks = 0;
  assign lvl = {levelBitHigh, levelBitLow};
  // ****************
  // design and core model
  // ****************
  nirqh_ctrl #(.WAKE_COUNT(WAKE)) dut (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irqReq, .extEdgeMode, .watchdogEnable, .instrDone,
    .unmaskInstr(instr[0]), .maskInstr(instr[1]), .haltInstr(instr[2]), .waitForIrqInstr(instr[3]), .trapInstr,
    .irqReturnInstr(instr[5]), .popFlagsInstr(instr[6]), .stackLevel, .serviceStart, .serviceVector,
    .levelBitHigh, .levelBitLow, .jumpIfMasked, .jumpIfUnmasked, .cpuStall, .oscRunning, .periphClockEnable,
    .watchdogReset);
  nirqh_core_model core (.clk, .srst, .run, .trapReq, .cpuStall, .instrDone, .trapInstr);
  // 20 ns clock
  initial begin
    forever #10 clk = ~clk;
  end
  // ****************
  // shared tasks
  // ****************
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // one single-word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    bus(1'b1, a, d, v);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    bus(1'b0, a, 8'h00, v);
    `CHK("reg", v, e)
    `CHK("resp", hresp, 1'b0)
  endtask
  task automatic stop;
    run <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic pulse(input int i, input logic [1:0] s);
    instr <= 7'h01 << i;
    stackLevel <= s;
    @(posedge clk);
    instr <= 7'h00;
    @(posedge clk);
  endtask
  // wait for an entry, then judge vector and loaded level
  task automatic svc(input logic [3:0] v, input logic [1:0] l);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (serviceStart !== 1'b1 && n < 40);
    `CHK("start", serviceStart, 1'b1)
    `CHK("vec", serviceVector, v)
    `CHK("lvl", lvl, l)
  endtask
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      `CHK("idle", serviceStart, 1'b0)
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset;
    svc(VEC_RESET, LVL3);
    `CHK("run", periphClockEnable, 1'b1)
    for (int i = 0; i < 4; i++) rdc(8'h70 + 8'(4 * i), PRIO_RESET);
    rdc(8'h80, CC_RESET);
    rdc(8'hA0, 8'h00);
  endtask
  task automatic t_regs;
    wr(8'h70, 8'hCF);
    wr(8'h70, 8'h64);
    rdc(8'h70, 8'h44);
    wr(8'h7C, 8'h0C);
    rdc(8'h7C, 8'hFC);
    wr(8'h80, 8'h08);
    rdc(8'h80, 8'hCA);
    wr(8'h78, 8'hC7);
  endtask
  task automatic t_instr;
    int op [5] = '{0, 1, 6, 3, 5};
    logic [1:0] st [5] = '{2'h0, 2'h0, LVL1, 2'h0, LVL3};
    logic [1:0] ex [5] = '{LVL0, LVL3, LVL1, LVL0, LVL3};
    for (int i = 0; i < 5; i++) begin
      pulse(op[i], st[i]);
      `CHK("lvl", lvl, ex[i])
      `CHK("jump", jumpIfMasked, ex[i] == LVL3)
    end
  endtask
  task automatic t_arb;
    irqReq <= 14'h1600;
    pulse(0, 2'h0);
    run <= 1'b1;
    svc(4'hA, LVL2);
    quiet(12);
    stop;
    irqReq[10] <= 1'b0;
    pulse(5, LVL0);
    run <= 1'b1;
    svc(4'hC, LVL2);
    stop;
    irqReq[12] <= 1'b0;
    pulse(5, LVL0);
    run <= 1'b1;
    svc(4'h9, LVL1);
    wr(8'h78, 8'hC3);
    svc(4'h9, LVL2);
    stop;
    irqReq <= 14'h0000;
  endtask
  task automatic t_halt(input logic osc_irq_enable, input int wv, input logic [1:0] exL);
    int n;
    n = 0;
    wr(8'h84, {6'h00, osc_irq_enable, 1'b0});
    watchdogEnable <= 1'b1;
    pulse(2, 2'h0);
    `CHK("osc", oscRunning, osc_irq_enable)
    `CHK("lvl", lvl, LVL0)
    rdc(8'h88, osc_irq_enable ? 8'h02 : 8'h0A);
    irqReq[9] <= 1'b1;
    quiet(20);
    `CHK("stall", cpuStall, 1'b1)
    irqReq <= irqReq | (14'h0001 << wv);
    do begin
      @(posedge clk);
      n++;
    end while (cpuStall === 1'b1 && n < 100);
    `CHK("wake", n inside {[WAKE + 1:WAKE + 3]}, 1'b1)
    run <= 1'b1;
    svc(4'(wv), exL);
    if (!osc_irq_enable) svc(4'h9, LVL2);
    stop;
    irqReq <= 14'h0000;
    pulse(1, 2'h0);
  endtask
  task automatic t_nmi;
    run <= 1'b1;
    irqReq[0] <= 1'b1;
    svc(VEC_NMI, LVL3);
    trapReq <= 1'b1;
    svc(VEC_TRAP, LVL3);
    trapReq <= 1'b0;
    quiet(10);
    stop;
    // one-cycle pulse on an edge-mode external group must still be served
    extEdgeMode <= 5'h01;
    irqReq <= 14'h0002;
    @(posedge clk);
    irqReq <= 14'h0000;
    pulse(0, 2'h0);
    run <= 1'b1;
    svc(4'h1, LVL1);
    quiet(10);
    stop;
  endtask
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset;
    t_regs;
    t_instr;
    t_arb;
    t_halt(1'b0, 3, LVL1);
    t_halt(1'b1, 6, LVL3);
    t_nmi;
    final_report;
  end
  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report;
  end
endmodule
